// [rtl/sot_pkg.sv]
// Shared constants and types for the secondary oscillator timer block
package sot_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses, one aligned 32-bit word each)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_TLOW = 8'h00;
  localparam logic [7:0] OFF_THIGH = 8'h04;
  localparam logic [7:0] OFF_TCTRL = 8'h08;
  localparam logic [7:0] OFF_OSCCTL = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////////
  // timer_control_register fields
  localparam int TC_BUF_BIT = 7;
  localparam int TC_FLAG_BIT = 6;
  localparam int TC_PS_LSB = 4;
  localparam int TC_OSCEN_BIT = 3;
  localparam int TC_EXT_BIT = 1;
  localparam int TC_ON_BIT = 0;
  localparam logic [7:0] TCTRL_RST = 8'h00;
  localparam logic [7:0] TCTRL_WMASK = 8'hbb;

  ////////////////////////////////////////////////////////////////////////////////
  // oscillator_control_register fields
  localparam int OC_IDLE_ON_SLEEP_ENABLE_BIT = 7;
  localparam int OC_MODE_LSB = 2;
  localparam int OC_SCS_LSB = 0;
  localparam logic [7:0] OSCCTL_RST = 8'h00;

  // System clock select codes
  localparam logic [1:0] SCS_PRIMARY = 2'h0;
  localparam logic [1:0] SCS_SECONDARY = 2'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and prescaler
  localparam int CNT_W = 16;
  localparam int PS_W = 3;
  localparam logic [7:0] TCNT_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int FAIL_TIMEOUT_NS = 100000;
  localparam int FAIL_CYCLES = (FAIL_TIMEOUT_NS * CLK_MHZ + 999) / 1000;

  // Power-managed modes, one-hot
  typedef enum logic [4:0] {
    PM_PRI_RUN = 5'b00001,
    PM_SECONDARY_RUN_MODE = 5'b00010,
    PM_SECONDARY_IDLE_MODE = 5'b00100,
    PM_PRI_IDLE = 5'b01000,
    PM_SLEEP = 5'b10000
  } sot_pm_e;

endpackage

// [rtl/sot_prescale.sv]
// Clearable 1/2/4/8 prescaler turning count events into counter ticks
`timescale 1ns/1ps
module sot_prescale (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic event_in,
  input wire logic [1:0] sel,
  output logic tick
);

  logic [sot_pkg::PS_W-1:0] cnt_q;
  logic [sot_pkg::PS_W-1:0] limit;

  // Divide ratio minus one, 0 means every event ticks
  assign limit = sot_pkg::PS_W'((4'h1 << sel) - 4'h1);
  assign tick = event_in & ~clear & (cnt_q == limit);

  // Clear wins over counting so a reload starts a full prescale period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clear || tick) begin
      cnt_q <= '0;
    end else if (event_in) begin
      cnt_q <= cnt_q + sot_pkg::PS_W'(1);
    end
  end

endmodule

// [rtl/sot_sync.sv]
// Two-stage synchroniser with rising-edge pulse for the crystal input
`timescale 1ns/1ps
module sot_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out,
  output logic rise_pulse
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // Only the second stage and later are looked at by logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign rise_pulse = sync_q & ~last_q;

endmodule

// [rtl/sot_top.sv]
// Secondary oscillator timer: 16-bit counter, buffered access and clock control
`timescale 1ns/1ps

// Notes on behaviour
// - Buffered mode maps the high-byte address onto a separate buffer register.
// - Buffered mode: reading low byte snapshots live high byte into buffer.
// - Buffered mode: writing low byte also loads counter high from buffer.
// - Buffered mode gives no direct access to the live counter high byte.
// - High-byte writes keep the prescaler; low-byte writes clear it.
// - Crystal oscillator runs only while its enable bit is set.
// - Enabled oscillator keeps running in every power-managed mode.
// - Clock select secondary code enters secondary run, clocking core and peripherals.
// - Secondary run plus sleep with idle-enable clear enters secondary idle.
// - Secondary-clock flag is set exactly while the oscillator clocks the system.
// - With fail-safe monitor, flag shows whether the oscillator still clocks the system.
// - Low-power config bit selects low oscillator power; higher power by default.
module sot_top #(
  parameter int FAIL_CYCLES = sot_pkg::FAIL_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sot_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic crystal_input_pin,
  output logic crystal_output_pin,
  output logic osc_amp_enable,
  output logic osc_low_power,
  input wire logic low_power_osc_config,
  input wire logic fscm_enable,
  input wire logic sleep_request,
  input wire logic wake_event,
  output logic [1:0] active_clock_source,
  output logic cpu_clock_run,
  output logic periph_clock_run,
  output logic secondary_clock_active,
  output logic timer_overflow
);

  localparam int FW = $clog2(FAIL_CYCLES + 1);
  ////////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] cnt_lo_q;
  logic [7:0] cnt_hi_q;
  logic [7:0] hi_buf_q;
  logic [7:0] tctrl_q;
  logic [7:0] oscctl_q;
  logic [31:0] prdata_q;
  logic ready_q;
  logic err_q;
  logic lp_q;
  logic strap_done_q;
  logic fail_q;
  logic [FW-1:0] fail_cnt_q;
  logic xo_q;
  logic ovf_q;
  logic [1:0] src_q;
  logic flag_q;
  sot_pkg::sot_pm_e pm_q;
  sot_pkg::sot_pm_e pm_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire acc_phase = psel & penable;
  wire hit_tlow = (paddr == sot_pkg::OFF_TLOW);
  wire hit_thigh = (paddr == sot_pkg::OFF_THIGH);
  wire hit_tctrl = (paddr == sot_pkg::OFF_TCTRL);
  wire hit_oscctl = (paddr == sot_pkg::OFF_OSCCTL);
  wire hit_any = hit_tlow | hit_thigh | hit_tctrl | hit_oscctl;
  // Read data is sampled in the first access cycle, write commits on the last
  wire rd_sample = acc_phase & ~ready_q & ~pwrite;
  wire wr_commit = acc_phase & ready_q & pwrite & hit_any;
  wire wr_tlow = wr_commit & hit_tlow;
  wire wr_thigh = wr_commit & hit_thigh;
  wire wr_tctrl = wr_commit & hit_tctrl;
  wire wr_oscctl = wr_commit & hit_oscctl;
  wire rd_tlow = rd_sample & hit_tlow;

  // Control fields
  wire buf_mode = tctrl_q[sot_pkg::TC_BUF_BIT];
  wire osc_en = tctrl_q[sot_pkg::TC_OSCEN_BIT];
  wire ext_src = tctrl_q[sot_pkg::TC_EXT_BIT];
  wire tmr_on = tctrl_q[sot_pkg::TC_ON_BIT];
  wire [1:0] ps_sel = tctrl_q[sot_pkg::TC_PS_LSB +: 2];
  wire idle_on_sleep_enable = oscctl_q[sot_pkg::OC_IDLE_ON_SLEEP_ENABLE_BIT];
  wire [1:0] system_clock_select = oscctl_q[sot_pkg::OC_SCS_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////////
  // Crystal input synchroniser; edges only count while the oscillator runs
  logic xi_sync;
  logic xi_rise;

  sot_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(crystal_input_pin),
    .sync_out(xi_sync),
    .rise_pulse(xi_rise)
  );
  wire osc_edge = xi_rise & osc_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler and counter
  wire cnt_event = tmr_on & (ext_src ? osc_edge : 1'b1);
  logic tick;

  sot_prescale u_ps (
    .clk(clk),
    .rst_n(rst_n),
    .clear(wr_tlow),
    .event_in(cnt_event),
    .sel(ps_sel),
    .tick(tick)
  );

  wire [sot_pkg::CNT_W:0] cnt_inc = {1'b0, cnt_hi_q, cnt_lo_q} + 17'h00001;

  // Buffered mode selects the buffer as high-byte view
  wire [7:0] hi_view = buf_mode ? hi_buf_q : cnt_hi_q;

  // Counter low byte: bus writes take priority over a tick in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_lo_q <= sot_pkg::TCNT_RST;
    end else if (wr_tlow) begin
      cnt_lo_q <= pwdata[7:0];
    end else if (tick) begin
      cnt_lo_q <= cnt_inc[7:0];
    end
  end

  // Counter high byte
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_hi_q <= sot_pkg::TCNT_RST;
    end else if (wr_tlow && buf_mode) begin
      // High loads from buffer with low write
      cnt_hi_q <= hi_buf_q;
    end else if (wr_thigh && !buf_mode) begin
      // Direct write only outside buffered mode
      cnt_hi_q <= pwdata[7:0];
    end else if (tick) begin
      cnt_hi_q <= cnt_inc[15:8];
    end
  end

  // High-byte buffer: snapshot on low read, load on high write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_buf_q <= sot_pkg::TCNT_RST;
    end else if (rd_tlow && buf_mode) begin
      // Snapshot live high with low read
      hi_buf_q <= cnt_hi_q;
    end else if (wr_thigh && buf_mode) begin
      // Buffered high writes land in the buffer
      hi_buf_q <= pwdata[7:0];
    end
  end

  // Overflow pulse, set on the same edge that wraps the count to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= tick & ~wr_tlow & cnt_inc[sot_pkg::CNT_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers; the flag and mode fields are read-only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tctrl_q <= sot_pkg::TCTRL_RST;
    end else if (wr_tctrl) begin
      tctrl_q <= pwdata[7:0] & sot_pkg::TCTRL_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscctl_q <= sot_pkg::OSCCTL_RST;
    end else if (wr_oscctl) begin
      oscctl_q <= {pwdata[7], 5'h00, pwdata[1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator drive and power level
  // Amplifier follows the enable bit alone
  // Power mode never gates the oscillator
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xo_q <= 1'b0;
    end else begin
      xo_q <= osc_en & ~xi_sync;
    end
  end

  // Strap caught after reset release, higher power until then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lp_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      lp_q <= low_power_osc_config;
      strap_done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fail-safe monitor: a silent crystal while selected drops to primary
  wire sec_selected = (system_clock_select == sot_pkg::SCS_SECONDARY);
  wire fail_hit = (fail_cnt_q == FW'(FAIL_CYCLES));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_cnt_q <= '0;
    end else if (!sec_selected || !fscm_enable || osc_edge || fail_q) begin
      fail_cnt_q <= '0;
    end else begin
      fail_cnt_q <= fail_cnt_q + FW'(1);
    end
  end

  // Failure sticks until software moves the select away from secondary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_q <= 1'b0;
    end else if (fail_hit) begin
      fail_q <= 1'b1;
    end else if (wr_oscctl && pwdata[1:0] != sot_pkg::SCS_SECONDARY) begin
      fail_q <= 1'b0;
    end
  end

  // Failure moves the source off the oscillator
  wire src_sec = sec_selected & ~fail_q;
  wire [1:0] src_d = src_sec ? sot_pkg::SCS_SECONDARY :
                     (sec_selected ? sot_pkg::SCS_PRIMARY : system_clock_select);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_q <= sot_pkg::SCS_PRIMARY;
      flag_q <= 1'b0;
    end else begin
      src_q <= src_d;
      flag_q <= src_sec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-managed mode sequencer
  always_comb begin
    pm_d = pm_q;
    case (pm_q)
      sot_pkg::PM_PRI_RUN: begin
        if (src_sec) begin
          pm_d = sot_pkg::PM_SECONDARY_RUN_MODE;
        end else if (sleep_request) begin
          pm_d = idle_on_sleep_enable ? sot_pkg::PM_SLEEP : sot_pkg::PM_PRI_IDLE;
        end
      end
      sot_pkg::PM_SECONDARY_RUN_MODE: begin
        if (!src_sec) begin
          pm_d = sot_pkg::PM_PRI_RUN;
        end else if (sleep_request) begin
          // Idle enable clear gives secondary idle
          pm_d = idle_on_sleep_enable ? sot_pkg::PM_SLEEP : sot_pkg::PM_SECONDARY_IDLE_MODE;
        end
      end
      sot_pkg::PM_SECONDARY_IDLE_MODE, sot_pkg::PM_PRI_IDLE, sot_pkg::PM_SLEEP: begin
        if (wake_event) begin
          pm_d = src_sec ? sot_pkg::PM_SECONDARY_RUN_MODE : sot_pkg::PM_PRI_RUN;
        end
      end
      default: begin
        pm_d = sot_pkg::PM_PRI_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_q <= sot_pkg::PM_PRI_RUN;
    end else begin
      pm_q <= pm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so read data comes from a flop
  wire [7:0] tctrl_rd = {tctrl_q[7], flag_q, tctrl_q[5:0]};
  wire [7:0] oscctl_rd = {oscctl_q[7], 5'(pm_q), oscctl_q[1:0]};
  wire [7:0] rd_mux = hit_tlow ? cnt_lo_q :
                      hit_thigh ? hi_view :
                      hit_tctrl ? tctrl_rd :
                      hit_oscctl ? oscctl_rd : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (acc_phase && !ready_q) begin
      ready_q <= 1'b1;
      err_q <= ~hit_any;
      prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rd_mux};
    end else begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pready = ready_q;
  assign pslverr = err_q;
  assign prdata = prdata_q;
  assign crystal_output_pin = xo_q;
  assign osc_amp_enable = osc_en;
  assign osc_low_power = lp_q;
  assign active_clock_source = src_q;
  assign secondary_clock_active = flag_q;
  assign cpu_clock_run = (pm_q == sot_pkg::PM_PRI_RUN) | (pm_q == sot_pkg::PM_SECONDARY_RUN_MODE);
  assign periph_clock_run = (pm_q != sot_pkg::PM_SLEEP);
  assign timer_overflow = ovf_q;

endmodule

// [sim/sot_monitor.sv]
// Port-level checker for the secondary oscillator timer
`timescale 1ns/1ps
module sot_monitor #(
  parameter int FAIL_CYCLES = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic crystal_input_pin,
  input wire logic crystal_output_pin,
  input wire logic osc_amp_enable,
  input wire logic osc_low_power,
  input wire logic low_power_osc_config,
  input wire logic fscm_enable,
  input wire logic sleep_request,
  input wire logic wake_event,
  input wire logic [1:0] active_clock_source,
  input wire logic cpu_clock_run,
  input wire logic secondary_clock_active,
  input wire logic timer_overflow
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  // Count cycles without a crystal rising edge while the monitor should be watching
  logic pin_q;
  logic [15:0] quiet_q;
  logic [15:0] quiet_d;
  wire watch = fscm_enable && active_clock_source == sot_pkg::SCS_SECONDARY;
  wire rise = crystal_input_pin && !pin_q;
  assign quiet_d = (watch && !rise) ? quiet_q + 16'h1 : 16'h0;

  // Helper flops; margin in the bound covers the two-flop synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      quiet_q <= 16'h0;
    end else begin
      pin_q <= crystal_input_pin;
      quiet_q <= quiet_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  osc_drive_a: assert property (crystal_output_pin |-> $past(osc_amp_enable))
    else $error("crystal driven while oscillator disabled");
  osc_hold_a: assert property ($fell(osc_amp_enable) |-> $past(psel && penable && pwrite && pready))
    else $error("oscillator stopped without a register write");
  sleep_stop_a: assert property (sleep_request && cpu_clock_run |=> ##[0:1] !cpu_clock_run)
    else $error("core clock kept running after sleep request");
  wake_run_a: assert property (wake_event && !cpu_clock_run |-> ##[1:3] cpu_clock_run)
    else $error("core clock not restored after wake");
  flag_source_a: assert property (secondary_clock_active |->
      active_clock_source == sot_pkg::SCS_SECONDARY ||
      $past(active_clock_source) == sot_pkg::SCS_SECONDARY)
    else $error("secondary flag set while primary clocks the system");
  fail_bound_a: assert property (int'(quiet_q) <= FAIL_CYCLES + 8)
    else $error("silent crystal kept as system clock");
  strap_hold_a: assert property ($past(rst_n) |-> osc_low_power == $past(low_power_osc_config))
    else $error("oscillator power level differs from strap");
  ovf_pulse_a: assert property (timer_overflow |=> !timer_overflow)
    else $error("overflow pulse longer than one cycle");

  // Main scenarios reached
  cover property (sleep_request && cpu_clock_run);
  cover property (timer_overflow);
  cover property (fscm_enable && $fell(active_clock_source == sot_pkg::SCS_SECONDARY));
endmodule

bind sot_top sot_monitor #(.FAIL_CYCLES(FAIL_CYCLES)) u_sot_monitor (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .crystal_input_pin(crystal_input_pin),
  .crystal_output_pin(crystal_output_pin), .osc_amp_enable(osc_amp_enable),
  .osc_low_power(osc_low_power), .low_power_osc_config(low_power_osc_config),
  .fscm_enable(fscm_enable), .sleep_request(sleep_request), .wake_event(wake_event),
  .active_clock_source(active_clock_source), .cpu_clock_run(cpu_clock_run),
  .secondary_clock_active(secondary_clock_active), .timer_overflow(timer_overflow)
);

// [sim/sot_top_tb.sv]
// Self-checking bench for the secondary oscillator timer
`timescale 1ns/1ps
module sot_top_tb;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic err;
  } sot_row_s;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic strap = 1'b0;
  logic fscm = 1'b0;
  logic sleep_rq = 1'b0;
  logic wake = 1'b0;
  logic stall = 1'b0;
  logic pready, pslverr, xin, xout, amp, lowp, cpu_run, per_run, flag, ovf;
  logic [31:0] prdata;
  logic [1:0] src;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  sot_row_s rows [16] = '{
    '{1'b0, 8'h08, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'h04, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h00, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h00, 1'b0},
    '{1'b1, 8'h08, 32'hff, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'hbb, 1'b0},
    '{1'b1, 8'h08, 32'h00, 32'h0, 1'b0}, '{1'b1, 8'h04, 32'h5a, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h5a, 1'b0}, '{1'b1, 8'h00, 32'ha5, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'ha5, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h00, 1'b1},
    '{1'b1, 8'h14, 32'hff, 32'h0, 1'b1}, '{1'b1, 8'h08, 32'h30, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h30, 1'b0}, '{1'b1, 8'h08, 32'h00, 32'h0, 1'b0}
  };

  sot_top #(.FAIL_CYCLES(40)) u_sot_top (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .crystal_input_pin(xin), .crystal_output_pin(xout), .osc_amp_enable(amp),
    .osc_low_power(lowp), .low_power_osc_config(strap), .fscm_enable(fscm),
    .sleep_request(sleep_rq), .wake_event(wake), .active_clock_source(src),
    .cpu_clock_run(cpu_run), .periph_clock_run(per_run),
    .secondary_clock_active(flag), .timer_overflow(ovf)
  );
  sot_xtal u_sot_xtal (.clk(clk), .amp_on(amp), .stall(stall), .pin(xin));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer; request held until pready is seen high, one idle cycle after
  // No local wait limit: only the hang guard may end a stuck transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Sleep request then wake, checking which clocks stop meanwhile
  task automatic nap(input logic [2:0] e);
    sleep_rq <= 1'b1;
    @(posedge clk);
    sleep_rq <= 1'b0;
    repeat (3) @(posedge clk);
    chk({cpu_run, per_run, amp}, e);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    repeat (4) @(posedge clk);
    chk(cpu_run, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(lowp, 1'b0);
    // Register table rows
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(err, rows[i].err);
      if (!rows[i].wr) chk(rd, rows[i].e);
    end
    // Buffered access: writes go through buffer, low read snapshots live high
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b1, 8'h04, 32'h12);
    rchk(8'h04, 32'h12);
    apb(1'b1, 8'h00, 32'h34);
    apb(1'b1, 8'h04, 32'h77);
    rchk(8'h00, 32'h34);
    rchk(8'h04, 32'h12);
    // Carry from low into high byte during a short run
    apb(1'b1, 8'h04, 32'h00);
    apb(1'b1, 8'h00, 32'hfe);
    apb(1'b1, 8'h08, 32'h81);
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd & 32'hf0, 32'h0);
    rchk(8'h04, 32'h01);
    // Wrap of the full count
    apb(1'b1, 8'h04, 32'hff);
    apb(1'b1, 8'h00, 32'hfd);
    apb(1'b1, 8'h08, 32'h81);
    for (int n = 0; n < 40 && ovf !== 1'b1; n++) @(posedge clk);
    chk(ovf, 1'b1);
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b0, 8'h00, 32'h0);
    rchk(8'h04, 32'h00);
    // Prescale 1:8 on the clock: a high write between must not restart the prescaler
    apb(1'b1, 8'h08, 32'h31);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b1, 8'h04, 32'h00);
    apb(1'b1, 8'h08, 32'h00);
    rchk(8'h00, 32'h11);
    // Oscillator on, start-up wait, then run from it
    apb(1'b1, 8'h08, 32'h08);
    chk(amp, 1'b1);
    repeat (60) @(posedge clk);
    apb(1'b1, 8'h0c, 32'h01);
    repeat (3) @(posedge clk);
    chk({flag, src}, 3'b101);
    rchk(8'h08, 32'h48);
    rchk(8'h0c, 32'h09);
    nap(3'b011);
    apb(1'b1, 8'h0c, 32'h81);
    nap(3'b001);
    // Crystal stops with the monitor on: system falls back to primary
    fscm <= 1'b1;
    stall <= 1'b1;
    for (int n = 0; n < 200 && src !== 2'h0; n++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk({flag, src}, 3'b000);
    chk(xout, !xin);
    stall <= 1'b0;
    fscm <= 1'b0;
    apb(1'b1, 8'h0c, 32'h00);
    nap(3'b011);
    apb(1'b1, 8'h08, 32'h00);
    chk(amp, 1'b0);
    @(posedge clk);
    chk(xout, 1'b0);
    // Second reset with the low-power strap set
    rst_n <= 1'b0;
    strap <= 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(lowp, 1'b1);
    rchk(8'h08, 32'h00);
    results();
  end
endmodule

// [sim/sot_xtal.sv]
// Behavioural watch crystal, scaled to a fast period
`timescale 1ns/1ps
module sot_xtal #(
  parameter int HALF = 10,
  parameter int STARTUP = 30
) (
  input wire logic clk,
  input wire logic amp_on,
  input wire logic stall,
  output logic pin
);
  int cnt = 0;
  int warm = 0;
  initial pin = 1'b0;

  always @(posedge clk) begin
    if (!amp_on) begin
      warm <= 0;
      cnt <= 0;
    end else if (warm < STARTUP) begin
      warm <= warm + 1;
    end else if (!stall) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) pin <= ~pin;
    end
  end
endmodule
